// ---- hdl/tec_top.sv ----
// Control logic of the 16-bit timer/event counter with two capture/compare
// registers, output flip-flop, prescaler, edge select and pin direction
//
// Operation
// - Run mode: stop, free, edge clear, match clear
// - Running matches raise requests, may toggle output
// - Overflow flag sets on FFFFH rollover match
// - Register one role: compare or capture
// - Register zero role: compare or capture
// - Register zero trigger: secondary or opposite primary
// - Opposite trigger with both edges: no capture
// - Register one match toggles when enabled
// - Register zero match toggles when enabled
// - Set/reset bits drive flip-flop, read zero
// - Output disabled forces pin low
// - Secondary edge field decoding
// - Primary edge field decoding
// - Count clock: system clock, halves, eighths, edge
// - Reset-high input gives first rising edge
// - Counter increments while running, clears on stop
// - Two agreeing samples accept an edge
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"

module tec_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    input wire logic [15:0] cc_wdata,
    input wire logic cc_zero_wr,
    input wire logic cc_one_wr,
    output logic [15:0] count_register,
    output logic [15:0] cc_register_zero,
    output logic [15:0] cc_register_one,
    input wire logic shared_port_pin_in,
    output logic shared_port_pin_out,
    output logic shared_port_pin_oe,
    input wire logic secondary_input,
    output logic timer_output_pin,
    output logic match_request_zero,
    output logic match_request_one
);

    // --------------------------------------------------------
    // Register storage
    // --------------------------------------------------------
    tec_pkg::tec_tmc_t timer_mode_control;
    tec_pkg::tec_prm_t prescaler_edge_select;
    tec_pkg::tec_crc_t capture_compare_control;
    tec_pkg::tec_toc_t timer_output_control;
    logic [7:0] port2_direction;
    logic output_flipflop;
    logic [2:0] div_count;
    logic primed;
    tec_pkg::tec_edges_t pin_edges [2];

    logic running;
    logic sample_tick;
    logic count_tick;
    logic primary_valid;
    logic secondary_valid;
    logic primary_opposite;
    logic match_zero;
    logic match_one;
    logic clear_count;
    logic cap_zero;
    logic cap_one;
    logic ovf_event;
    logic next_flipflop;
    logic wr_tmc;
    logic wr_prm;
    logic wr_crc;
    logic wr_toc;
    logic wr_dir;

    // Selects one register when the access address matches it
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // Edge field decode: 10 is prohibited and yields no edge
    function automatic logic edge_valid(input tec_pkg::tec_edge_t sel,
                                        input tec_pkg::tec_edges_t e);
        unique case (sel)
            tec_pkg::TEC_EDGE_FALL: edge_valid = e.fall;
            tec_pkg::TEC_EDGE_RISE: edge_valid = e.rise;
            tec_pkg::TEC_EDGE_BOTH: edge_valid = e.rise || e.fall;
            default: edge_valid = 1'b0;
        endcase
    endfunction

    assign wr_tmc = mem_wr && hit(mem_addr, `TEC_ADDR_TMC);
    assign wr_prm = mem_wr && hit(mem_addr, `TEC_ADDR_PRM);
    assign wr_crc = mem_wr && hit(mem_addr, `TEC_ADDR_CRC);
    assign wr_toc = mem_wr && hit(mem_addr, `TEC_ADDR_TOC);
    assign wr_dir = mem_wr && hit(mem_addr, `TEC_ADDR_PORT2_DIR);

    // --------------------------------------------------------
    // Count clock and input edges
    // --------------------------------------------------------
    assign running = timer_mode_control.run_mode != tec_pkg::TEC_STOP;

    // Free divider; taps give the half and eighth rate ticks
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_count <= 3'h0;
        end else begin
            div_count <= div_count + 3'h1;
        end
    end

    // Prescaler tick; the edge clock samples inputs at the system clock rate
    always_comb begin
        unique case (prescaler_edge_select.clock_sel)
            tec_pkg::TEC_CLK_SYS: sample_tick = 1'b1;
            tec_pkg::TEC_CLK_DIV2:
                sample_tick = {2'h0, div_count[0]} == `TEC_DIV_2;
            tec_pkg::TEC_CLK_DIV8:
                sample_tick = div_count == `TEC_DIV_8;
            tec_pkg::TEC_CLK_EDGE: sample_tick = 1'b1;
        endcase
    end

    // Filters track once first enabled so a restart finds no stale edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            primed <= 1'b0;
        end else if (running) begin
            primed <= 1'b1;
        end
    end

    // Both inputs share one filter design
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filter
            tec_edge_filter u_filter (
                .core_clk(core_clk),
                .nrst(nrst),
                .sample(sample_tick),
                .track(running || primed),
                .pin(gi == 0 ? shared_port_pin_in : secondary_input),
                .edges(pin_edges[gi])
            );
        end
    endgenerate

    assign primary_valid =
        edge_valid(prescaler_edge_select.primary_edge, pin_edges[0]);
    assign secondary_valid =
        edge_valid(prescaler_edge_select.secondary_edge, pin_edges[1]);

    // Opposite primary edge; both-edges selection gives none
    always_comb begin
        unique case (prescaler_edge_select.primary_edge)
            tec_pkg::TEC_EDGE_FALL: primary_opposite = pin_edges[0].rise;
            tec_pkg::TEC_EDGE_RISE: primary_opposite = pin_edges[0].fall;
            default: primary_opposite = 1'b0;
        endcase
    end

    assign count_tick = running &&
        ((prescaler_edge_select.clock_sel == tec_pkg::TEC_CLK_EDGE) ?
         primary_valid : sample_tick);

    // --------------------------------------------------------
    // Counter, matches and overflow
    // --------------------------------------------------------
    // A match is taken on the count edge that leaves the matching value
    assign match_zero = count_tick && !capture_compare_control.reg_zero_role &&
                        count_register == cc_register_zero;
    assign match_one = count_tick && !capture_compare_control.reg_one_role &&
                       count_register == cc_register_one;
    assign ovf_event = count_tick && count_register == `TEC_CNT_MAX &&
                       cc_register_zero == `TEC_CNT_MAX;
    assign clear_count =
        (timer_mode_control.run_mode == tec_pkg::TEC_CLR_EDGE &&
         primary_valid) ||
        (timer_mode_control.run_mode == tec_pkg::TEC_CLR_MATCH &&
         count_tick && count_register == cc_register_zero);

    // Counter: zero while stopped, wraps on its own
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_register <= `TEC_CNT_ZERO;
        end else if (!running || clear_count) begin
            count_register <= `TEC_CNT_ZERO;
        end else if (count_tick) begin
            count_register <= count_register + 16'h0001;
        end
    end

    // --------------------------------------------------------
    // Capture/compare registers
    // --------------------------------------------------------
    assign cap_zero = running && capture_compare_control.reg_zero_role &&
        (capture_compare_control.reg_zero_trigger_sel ?
         primary_opposite : secondary_valid);
    assign cap_one = running && capture_compare_control.reg_one_role &&
                     primary_valid;

    // Capture wins over a software write in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cc_register_zero <= `TEC_CNT_ZERO;
        end else if (cap_zero) begin
            cc_register_zero <= count_register;
        end else if (cc_zero_wr) begin
            cc_register_zero <= cc_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cc_register_one <= `TEC_CNT_ZERO;
        end else if (cap_one) begin
            cc_register_one <= count_register;
        end else if (cc_one_wr) begin
            cc_register_one <= cc_wdata;
        end
    end

    // Requests pulse on a match or a capture, never while stopped
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            match_request_zero <= 1'b0;
            match_request_one <= 1'b0;
        end else begin
            match_request_zero <= match_zero || cap_zero;
            match_request_one <= match_one || cap_one;
        end
    end

    // --------------------------------------------------------
    // Control registers
    // --------------------------------------------------------
    // Mode register; a hardware overflow beats a clearing write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timer_mode_control <= `TEC_RST_CTRL;
        end else begin
            if (wr_tmc) begin
                timer_mode_control.run_mode <=
                    tec_pkg::tec_mode_t'(mem_wdata[3:2]);
            end
            if (ovf_event) begin
                timer_mode_control.overflow_flag <= 1'b1;
            end else if (wr_tmc && !mem_wdata[`TEC_OVF_BIT]) begin
                timer_mode_control.overflow_flag <= 1'b0;
            end
        end
    end

    // Prescaler/edge, capture control and port direction registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prescaler_edge_select <= `TEC_RST_CTRL;
            capture_compare_control <= `TEC_RST_CTRL;
            port2_direction <= `TEC_RST_PORT2_DIR;
        end else begin
            if (wr_prm) begin
                prescaler_edge_select <= mem_wdata & 8'hF3;
            end
            if (wr_crc) begin
                capture_compare_control <= mem_wdata & 8'h07;
            end
            if (wr_dir) begin
                port2_direction <= `TEC_PORT2_FIXED |
                                   (mem_wdata & `TEC_PORT2_RW_MASK);
            end
        end
    end

    // Output control; set and reset bits are commands, not storage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timer_output_control <= `TEC_RST_CTRL;
        end else if (wr_toc) begin
            timer_output_control <= mem_wdata & 8'h13;
        end
    end

    // --------------------------------------------------------
    // Output flip-flop and pins
    // --------------------------------------------------------
    // A software set/reset overrides a toggle in the same cycle
    always_comb begin
        next_flipflop = output_flipflop;
        if (match_zero && timer_output_control.reg_zero_invert_en) begin
            next_flipflop = !next_flipflop;
        end
        if (match_one && timer_output_control.reg_one_invert_en) begin
            next_flipflop = !next_flipflop;
        end
        if (wr_toc && mem_wdata[2] && !mem_wdata[3]) begin
            next_flipflop = 1'b0;
        end else if (wr_toc && mem_wdata[3] && !mem_wdata[2]) begin
            next_flipflop = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            output_flipflop <= 1'b0;
        end else begin
            output_flipflop <= next_flipflop;
        end
    end

    // Pin stage: one cycle after the flip-flop, held low when disabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timer_output_pin <= 1'b0;
            shared_port_pin_out <= 1'b0;
            shared_port_pin_oe <= 1'b0;
        end else begin
            timer_output_pin <= timer_output_control.output_enable_bit &&
                                output_flipflop;
            shared_port_pin_out <= timer_output_control.output_enable_bit &&
                                   output_flipflop;
            shared_port_pin_oe <=
                !port2_direction[`TEC_SHARED_PIN_BIT];
        end
    end

    // --------------------------------------------------------
    // Read port
    // --------------------------------------------------------
    // Registered read; unmapped addresses read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mem_rdata <= 8'h00;
        end else if (mem_rd) begin
            if (hit(mem_addr, `TEC_ADDR_TMC)) begin
                mem_rdata <= timer_mode_control;
            end else if (hit(mem_addr, `TEC_ADDR_PRM)) begin
                mem_rdata <= prescaler_edge_select;
            end else if (hit(mem_addr, `TEC_ADDR_CRC)) begin
                mem_rdata <= capture_compare_control;
            end else if (hit(mem_addr, `TEC_ADDR_TOC)) begin
                mem_rdata <= timer_output_control;
            end else if (hit(mem_addr, `TEC_ADDR_PORT2_DIR)) begin
                mem_rdata <= port2_direction;
            end else begin
                mem_rdata <= 8'h00;
            end
        end
    end

    // --------------------------------------------------------
    // Checks
    // --------------------------------------------------------
    a_stop_clears_count: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !running |=> count_register == `TEC_CNT_ZERO)
        else $error("count not zero after stop");

    a_count_increments: assert property (
        @(posedge core_clk) disable iff (!nrst)
        count_tick && !clear_count |=>
            count_register == $past(count_register) + 16'h0001)
        else $error("count did not step by one");

    a_stop_no_request: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !running |=> !match_request_zero && !match_request_one)
        else $error("request raised while stopped");

    a_overflow_sets: assert property (
        @(posedge core_clk) disable iff (!nrst)
        running && count_register == `TEC_CNT_MAX &&
        cc_register_zero == `TEC_CNT_MAX && count_tick
        |=> timer_mode_control.overflow_flag && count_register == 16'h0000)
        else $error("overflow flag not set on rollover");

    a_overflow_clears: assert property (
        @(posedge core_clk) disable iff (!nrst)
        wr_tmc && !mem_wdata[0] && !ovf_event
        |=> !timer_mode_control.overflow_flag)
        else $error("overflow flag not cleared by write");

    a_pin_forced_low: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !timer_output_control.output_enable_bit |=> !timer_output_pin)
        else $error("output pin high while disabled");

    a_toggle_one: assert property (
        @(posedge core_clk) disable iff (!nrst)
        match_one && timer_output_control.reg_one_invert_en && !wr_toc &&
        !(match_zero && timer_output_control.reg_zero_invert_en)
        |=> output_flipflop != $past(output_flipflop))
        else $error("flip-flop not toggled on register one match");

    a_setreset_reads_zero: assert property (
        @(posedge core_clk) disable iff (!nrst)
        mem_rd && mem_addr == `TEC_ADDR_TOC |=> mem_rdata[3:2] == 2'h0)
        else $error("set/reset bits read as one");

    a_both_edges_no_cap: assert property (
        @(posedge core_clk) disable iff (!nrst)
        capture_compare_control.reg_zero_trigger_sel &&
        prescaler_edge_select.primary_edge == tec_pkg::TEC_EDGE_BOTH
        |-> !cap_zero)
        else $error("capture with opposite trigger and both edges");

endmodule
`default_nettype wire

// ---- hdl/tec_cfg.svh ----
// Address map, field positions, reset values and timing counts of the timer
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TEC_ADDR_PORT2_DIR 16'hFF22
`define TEC_ADDR_TMC 16'hFFA6
`define TEC_ADDR_PRM 16'hFFA7
`define TEC_ADDR_CRC 16'hFFA8
`define TEC_ADDR_TOC 16'hFFA9

// ----------------------------------------------------------------
// Reset values and fixed bits
// ----------------------------------------------------------------
`define TEC_RST_PORT2_DIR 8'hFF
`define TEC_RST_CTRL 8'h00
`define TEC_PORT2_FIXED 8'hE0
`define TEC_PORT2_RW_MASK 8'h1F
`define TEC_SHARED_PIN_BIT 3
`define TEC_OVF_BIT 0

// ----------------------------------------------------------------
// Counter values and timing
// ----------------------------------------------------------------
`define TEC_CNT_MAX 16'hFFFF
`define TEC_CNT_ZERO 16'h0000
`define TEC_SYS_PERIOD_NS 20
`define TEC_DIV_2 3'h1
`define TEC_DIV_8 3'h7
`define TEC_FILTER_SAMPLES 2

`endif

// ---- hdl/tec_pkg.sv ----
// Types shared by the timer/event counter control logic
package tec_pkg;

    // Run mode field encodings
    typedef enum logic [1:0] {
        TEC_STOP = 2'h0,
        TEC_FREE = 2'h1,
        TEC_CLR_EDGE = 2'h2,
        TEC_CLR_MATCH = 2'h3
    } tec_mode_t;

    // Edge select field encodings
    typedef enum logic [1:0] {
        TEC_EDGE_FALL = 2'h0,
        TEC_EDGE_RISE = 2'h1,
        TEC_EDGE_BAD = 2'h2,
        TEC_EDGE_BOTH = 2'h3
    } tec_edge_t;

    // Count clock field encodings
    typedef enum logic [1:0] {
        TEC_CLK_SYS = 2'h0,
        TEC_CLK_DIV2 = 2'h1,
        TEC_CLK_DIV8 = 2'h2,
        TEC_CLK_EDGE = 2'h3
    } tec_clk_t;

    typedef struct packed {
        logic [3:0] unused_hi;
        tec_mode_t run_mode;
        logic unused_lo;
        logic overflow_flag;
    } tec_tmc_t;

    typedef struct packed {
        tec_edge_t secondary_edge;
        tec_edge_t primary_edge;
        logic [1:0] unused;
        tec_clk_t clock_sel;
    } tec_prm_t;

    typedef struct packed {
        logic [4:0] unused;
        logic reg_one_role;
        logic reg_zero_trigger_sel;
        logic reg_zero_role;
    } tec_crc_t;

    typedef struct packed {
        logic [2:0] unused;
        logic reg_one_invert_en;
        logic flipflop_set;
        logic flipflop_reset;
        logic reg_zero_invert_en;
        logic output_enable_bit;
    } tec_toc_t;

    // Edge events from one filtered input
    typedef struct packed {
        logic rise;
        logic fall;
    } tec_edges_t;

endpackage

// ---- hdl/tec_edge_filter.sv ----
// Two-sample noise filter and edge detector for one timer input pin
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"

module tec_edge_filter (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sample,
    input wire logic track,
    input wire logic pin,
    output var tec_pkg::tec_edges_t edges
);

    logic samp_a;
    logic samp_b;
    logic level;
    logic stable;

    // A new level counts only once two successive samples agree
    assign stable = (samp_a == samp_b) && (samp_b != level);

    // --------------------------------------------------------
    // Sampling at the prescaler tick
    // --------------------------------------------------------
    // Level starts low, so a pin held high out of reset shows a rising
    // edge at first enable; later stops keep tracking, hiding it then
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            samp_a <= 1'b0;
            samp_b <= 1'b0;
            level <= 1'b0;
        end else if (sample && track) begin
            samp_a <= pin;
            samp_b <= samp_a;
            if (stable) begin
                level <= samp_b;
            end
        end
    end

    // One-cycle edge pulses
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edges <= '0;
        end else begin
            edges.rise <= sample && track && stable && samp_b;
            edges.fall <= sample && track && stable && !samp_b;
        end
    end

endmodule
`default_nettype wire

// ---- verif/tec_pin_model.sv ----
// Model of the outside world at the shared timer pin
`timescale 1ns/1ps
`default_nettype none

module tec_pin_model (
    input wire logic oe,
    input wire logic out,
    input wire logic ext_lvl,
    output logic pin
);
    // The port owns the wire while it is an output, else the source does
    // Trigger pulses are held many count clocks; a one-cycle noise
    // pulse is only sent on purpose to exercise the input filter
    assign pin = oe ? out : ext_lvl;
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench for the timer/event counter control block
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"

module tb_top;
    logic core_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, cz = 1'b0;
    logic sec = 1'b0, ext = 1'b0, pin, oe, po, top, mz, mo;
    logic [15:0] addr = 16'h0000, ccw = 16'h0000, cnt, c0, c1;
    logic [7:0] wd = 8'h00, rdata;
    int failures = 0, checked = 0, i, t;
    logic [15:0] ad [5] = '{`TEC_ADDR_PORT2_DIR, `TEC_ADDR_TMC,
        `TEC_ADDR_PRM, `TEC_ADDR_CRC, `TEC_ADDR_TOC};
    logic [7:0] rv [5] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [5] = '{8'hFF, 8'h0C, 8'hF3, 8'h07, 8'h13};
    logic [7:0] wv [5] = '{8'hFF, 8'h0D, 8'hFF, 8'hFF, 8'hF7};
    logic [15:0] dv [3] = '{16'h0005, 16'h000A, 16'h0028};

    // 50 MHz system clock
    always #10 core_clk = ~core_clk;

    tec_top u_dut (.core_clk(core_clk), .nrst(nrst), .mem_addr(addr),
        .mem_wdata(wd), .mem_wr(wr), .mem_rd(rd), .mem_rdata(rdata),
        .cc_wdata(ccw), .cc_zero_wr(cz), .cc_one_wr(1'b0),
        .count_register(cnt), .cc_register_zero(c0), .cc_register_one(c1),
        .shared_port_pin_in(pin), .shared_port_pin_out(po),
        .shared_port_pin_oe(oe), .secondary_input(sec),
        .timer_output_pin(top), .match_request_zero(mz),
        .match_request_one(mo));

    tec_pin_model u_pin (.oe(oe), .out(po), .ext_lvl(ext), .pin(pin));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge core_clk);
        wr = 1'b0;
    endtask

    // Read data is registered, so it is looked at one cycle later
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(negedge core_clk);
        addr = a;
        rd = 1'b1;
        @(negedge core_clk);
        rd = 1'b0;
        @(negedge core_clk);
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask

    task automatic set_cc(input logic [15:0] v);
        @(negedge core_clk);
        ccw = v;
        cz = 1'b1;
        @(negedge core_clk);
        cz = 1'b0;
    endtask

    // Bounded wait for a request pulse; n returns the cycles waited
    task automatic wait_req(input bit one, input int lim, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (((one ? mo : mz) !== 1'b1) && n < lim);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog sized for the full counter wrap plus margin
    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        test_done;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        for (i = 0; i < 5; i++) rd_reg(ad[i], rv[i]);
        for (i = 1; i < 5; i++) begin
            wr_reg(ad[i], wv[i]);
            rd_reg(ad[i], mk[i]);
            wr_reg(ad[i], 8'h00);
        end
        wr_reg(16'hFFAA, 8'h5A);
        rd_reg(16'hFFAA, 8'h00);
        $display("test registers done");
        // Enable first, then set, never both in one write
        wr_reg(ad[4], 8'h01);
        wr_reg(ad[4], 8'h08);
        wr_reg(ad[4], 8'h01);
        @(negedge core_clk);
        chk("out_pin", 16'h0001, {15'h0000, top});
        chk("port_out", 16'h0001, {15'h0000, po});
        rd_reg(ad[4], 8'h01);
        wr_reg(ad[4], 8'h02);
        @(negedge core_clk);
        chk("out_pin", 16'h0000, {15'h0000, top});
        wr_reg(ad[4], 8'h13);
        set_cc(16'h0004);
        wr_reg(ad[1], 8'h0C);
        wait_req(0, 50, t);
        chk("match_wait", 16'h0005, 16'(t));
        repeat (2) @(negedge core_clk);
        chk("out_pin", 16'h0000, {15'h0000, top});
        $display("test output done");
        for (i = 0; i < 3; i++) begin
            wr_reg(ad[1], 8'h00);
            wr_reg(ad[2], 8'(i));
            wr_reg(ad[1], 8'h0C);
            wait_req(0, 100, t);
            wait_req(0, 100, t);
            chk("period", dv[i], 16'(t));
        end
        wr_reg(ad[1], 8'h00);
        @(negedge core_clk);
        chk("count", 16'h0000, cnt);
        wr_reg(ad[2], 8'h00);
        set_cc(16'hFFFF);
        wr_reg(ad[1], 8'h04);
        wait_req(0, 70000, t);
        repeat (2) @(negedge core_clk);
        rd_reg(ad[1], 8'h05);
        wr_reg(ad[1], 8'h04);
        rd_reg(ad[1], 8'h04);
        wr_reg(ad[1], 8'h00);
        $display("test counting done");
        wr_reg(ad[3], 8'h04);
        wr_reg(ad[2], 8'h50);
        wr_reg(ad[1], 8'h04);
        repeat (20) @(negedge core_clk);
        ext = 1'b1;
        @(negedge core_clk);
        ext = 1'b0;
        wait_req(1, 10, t);
        chk("glitch_wait", 16'h000A, 16'(t));
        ext = 1'b1;
        wait_req(1, 20, t);
        chk("capture_one", cnt, c1 + 16'h0001);
        chk("capture_wait", 16'h0004, 16'(t));
        wr_reg(ad[1], 8'h00);
        wr_reg(ad[3], 8'h01);
        wr_reg(ad[1], 8'h04);
        sec = 1'b1;
        wait_req(0, 20, t);
        chk("capture_zero", cnt, c0 + 16'h0001);
        chk("capture_wait", 16'h0004, 16'(t));
        wr_reg(ad[1], 8'h00);
        wr_reg(ad[3], 8'h03);
        wr_reg(ad[2], 8'h30);
        wr_reg(ad[1], 8'h04);
        ext = 1'b0;
        wait_req(0, 20, t);
        chk("no_capture", 16'h0014, 16'(t));
        wr_reg(ad[1], 8'h00);
        // Primary edges as count clock; no capture or edge clear with it
        wr_reg(ad[3], 8'h00);
        wr_reg(ad[2], 8'h13);
        wr_reg(ad[1], 8'h04);
        for (i = 0; i < 3; i++) begin
            ext = 1'b1;
            repeat (10) @(negedge core_clk);
            ext = 1'b0;
            repeat (10) @(negedge core_clk);
        end
        chk("edge_count", 16'h0003, cnt);
        wr_reg(ad[1], 8'h00);
        $display("test capture done");
        wr_reg(ad[0], 8'hF7);
        @(negedge core_clk);
        chk("pin_oe", 16'h0001, {15'h0000, oe});
        $display("test port done");
        test_done;
    end
endmodule

`default_nettype wire
